// file: design/emb_pkg.sv
// Package for the embedded memory block: constants, types, carriers
// Summary of operation
// - Quad mode: two reads, two writes together
// - Read and write widths chosen per port
// - Quad/true dual: 256x16 down to 4096x1
// - Dual and single port add 128x32
// - Port width ratios limited to sixteen
// - Block splits into two independent halves
// - Write pulse generated internally from clock
// - Read/write mode: write and read enables
// - Input/output mode: inputs share one enable
// - Each port: read, write enables, clear
// - Port registers clearable locally, globally, reset
// - Dual port uses port A only, unless split
// - Single port: shared address, two per block
// - Parallel search returns address and flag
// - Search memory holds 32 words of 32
// - Don't-care bits never block a match
// - Encoded result is binary matching location
// - Unencoded: 16 lines, one bank select
// - Select one gives odd, zero even
// - Single match: two-cycle write, one-cycle search
// - Multiple match: 32 locations over two cycles
// - Fast multiple match: 16 words, one cycle
// - Don't-care write needs a third cycle
// - Search words loadable at reset or run
package emb_pkg;
  localparam int MEM_BITS = 4096;
  localparam int CAM_WORDS = 32;
  localparam int CAM_W = 32;
  localparam int LINES = 16;
  localparam int DW = 32;
  localparam int AW = 12;
  localparam logic [2:0] W_X32 = 3'h5;
  localparam logic [2:0] RATIO_MAX = 3'h4;
  localparam int CAM_SEL_BIT = 31;
  localparam logic [31:0] CAM_SEL_MASK = 32'h7fff_ffff;
  localparam logic [31:0] FAST_MASK = 32'h0000_ffff;
  localparam logic [5:0] CFG_IDX = 6'h00;
  localparam logic [5:0] STAT_IDX = 6'h01;
  localparam logic [31:0] CFG_WMASK = 32'h00f7_777f;
  localparam logic [31:0] CFG_RST = 32'h0004_4440;

  typedef enum logic [1:0] {
    EMB_QUAD = 2'b00, EMB_TDP = 2'b01, EMB_DP = 2'b10, EMB_SP = 2'b11
  } emb_mode_e;
  typedef enum logic [1:0] {
    EMB_SINGLE = 2'b00, EMB_MULTI = 2'b01, EMB_FAST = 2'b10, EMB_RSV = 2'b11
  } emb_cmode_e;
  typedef enum logic [1:0] {
    EMB_IDLE = 2'b00, EMB_WR1 = 2'b01, EMB_WR2 = 2'b10, EMB_WR3 = 2'b11
  } emb_cst_e;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic cam_enc;
    emb_cmode_e cam_mode;
    logic cam_en;
    logic rsvd19;
    logic [2:0] rb_w;
    logic rsvd15;
    logic [2:0] wb_w;
    logic rsvd11;
    logic [2:0] ra_w;
    logic rsvd7;
    logic [2:0] wa_w;
    logic clk_io;
    logic split;
    emb_mode_e mode;
  } emb_cfg_s;

  typedef struct packed {
    logic wr_clken;
    logic rd_clken;
    logic clr;
    logic wreq;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic read_strobe;
    logic [AW-1:0] raddr;
  } emb_ram_in_s;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [CAM_W-1:0] wdata;
    logic [CAM_W-1:0] care;
    logic search;
    logic [CAM_W-1:0] key;
  } emb_cam_in_s;

  typedef struct packed {
    logic valid;
    logic match;
    logic [4:0] addr;
    logic [LINES-1:0] lines;
  } emb_cam_out_s;
endpackage

// file: design/emb_block.sv
// Embedded memory block: multi-port RAM and searchable memory
`timescale 1ns/10ps
module emb_block #(
  parameter logic [emb_pkg::CAM_WORDS*emb_pkg::CAM_W-1:0] CAM_INIT_DATA = '0,
  parameter logic [emb_pkg::CAM_WORDS*emb_pkg::CAM_W-1:0] CAM_INIT_CARE = '1,
  parameter logic [emb_pkg::CAM_WORDS-1:0] CAM_INIT_VLD = '0
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic glb_clr_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // RAM ports, index 0 is port A, 1 is port B
  input emb_pkg::emb_ram_in_s [1:0] ram_i,
  output logic [1:0][emb_pkg::DW-1:0] rdata_o,
  // Search memory
  input emb_pkg::emb_cam_in_s cam_i,
  output emb_pkg::emb_cam_out_s cam_o,
  output logic cam_busy_o,
  output logic cfg_err_o
);
  typedef struct packed {
    logic [emb_pkg::MEM_BITS-1:0] mem;
    logic [1:0] w_req;
    logic [1:0][emb_pkg::AW-1:0] w_addr;
    logic [1:0][emb_pkg::DW-1:0] w_data;
    logic [1:0] r_req;
    logic [1:0][emb_pkg::AW-1:0] r_addr;
    logic [1:0][emb_pkg::DW-1:0] dout;
    emb_pkg::emb_cfg_s cfg;
    logic ack;
    logic [31:0] wb_dat;
    logic [emb_pkg::CAM_WORDS-1:0][emb_pkg::CAM_W-1:0] cam_data;
    logic [emb_pkg::CAM_WORDS-1:0][emb_pkg::CAM_W-1:0] cam_care;
    logic [emb_pkg::CAM_WORDS-1:0] cam_vld;
    emb_pkg::emb_cst_e cam_st;
    logic [4:0] cw_addr;
    logic [emb_pkg::CAM_W-1:0] cw_data;
    logic [emb_pkg::CAM_W-1:0] cw_care;
    logic cam_ph;
    logic [emb_pkg::CAM_WORDS-1:0] hit_hold;
    emb_pkg::emb_cam_out_s cout;
  } emb_state_s;

  emb_state_s st_ff;
  emb_state_s nxt_st;

  // Bit address of a word of width 2**w, kept in one half when split
  function automatic logic [11:0] bit_base(input logic [11:0] a,
                                           input logic [2:0] w,
                                           input logic split,
                                           input logic pb);
    logic [11:0] b;
    b = 12'(a << w);
    if (split) begin
      b = {pb, b[10:0]};
    end
    return b;
  endfunction

  // Lowest set bit of a hit vector
  function automatic logic [4:0] lowest(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  logic [1:0] act;
  logic [1:0][2:0] ww;
  logic [1:0][2:0] rw;
  logic err;
  logic [2:0] wmin;
  logic [2:0] wmax;
  logic [31:0] hits;
  logic [31:0] cmask;
  logic [11:0] base;
  logic rd_in_en;
  logic r_do;
  logic [emb_pkg::DW-1:0] rd;

  // Port activity and width legality
  always_comb begin
    ww[0] = st_ff.cfg.wa_w;
    rw[0] = st_ff.cfg.ra_w;
    ww[1] = st_ff.cfg.wb_w;
    rw[1] = st_ff.cfg.rb_w;
    for (int p = 0; p < 2; p++) begin
      // Port B serves dual/single modes only as the second half
      act[p] = !st_ff.cfg.cam_en && (p == 0 || st_ff.cfg.split ||
               st_ff.cfg.mode == emb_pkg::EMB_QUAD ||
               st_ff.cfg.mode == emb_pkg::EMB_TDP);
    end
    wmin = 3'h7;
    wmax = 3'h0;
    err = 1'b0;
    for (int p = 0; p < 2; p++) begin
      if (act[p]) begin
        if (ww[p] < wmin) wmin = ww[p];
        if (rw[p] < wmin) wmin = rw[p];
        if (ww[p] > wmax) wmax = ww[p];
        if (rw[p] > wmax) wmax = rw[p];
      end
    end
    if (wmax > emb_pkg::W_X32) begin
      err = 1'b1;
    end
    if (wmax == emb_pkg::W_X32 && (st_ff.cfg.mode == emb_pkg::EMB_QUAD ||
        st_ff.cfg.mode == emb_pkg::EMB_TDP || st_ff.cfg.split)) begin
      err = 1'b1;
    end
    if (act != 2'b00 && wmax - wmin > emb_pkg::RATIO_MAX) begin
      err = 1'b1;
    end
    // Compare all stored words at once
    cmask = '1;
    if (st_ff.cfg.cam_mode == emb_pkg::EMB_SINGLE && !st_ff.cfg.cam_enc) begin
      cmask = emb_pkg::CAM_SEL_MASK;
    end
    for (int i = 0; i < emb_pkg::CAM_WORDS; i++) begin
      hits[i] = st_ff.cam_vld[i] && (((cam_i.key ^ st_ff.cam_data[i]) &
                st_ff.cam_care[i] & cmask) == '0);
    end
    if (st_ff.cfg.cam_mode == emb_pkg::EMB_FAST) begin
      hits = hits & emb_pkg::FAST_MASK;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    base = '0;
    rd_in_en = 1'b0;
    r_do = 1'b0;
    rd = '0;
    if (ce_i) begin
      // Pulses only end while enabled, so a low enable freezes them too
      nxt_st.ack = 1'b0;
      nxt_st.cout.valid = 1'b0;
      // Wishbone: one wait state, ack for a single cycle
      if (wb_cyc_i && wb_stb_i && !st_ff.ack) begin
        nxt_st.ack = 1'b1;
        nxt_st.wb_dat = '0;
        if (wb_adr_i[7:2] == emb_pkg::CFG_IDX) begin
          nxt_st.wb_dat = st_ff.cfg;
          if (wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
              if (wb_sel_i[b]) begin
                nxt_st.cfg[8*b +: 8] = wb_dat_i[8*b +: 8] &
                                       emb_pkg::CFG_WMASK[8*b +: 8];
              end
            end
          end
        end else if (wb_adr_i[7:2] == emb_pkg::STAT_IDX) begin
          nxt_st.wb_dat = {19'h00000, st_ff.cout.addr, 5'h00,
                           st_ff.cout.match, cam_busy_o, err};
        end
      end

      // RAM ports
      for (int p = 0; p < 2; p++) begin
        // Writes take effect from the registered request, old data read
        if (st_ff.w_req[p]) begin
          base = bit_base(st_ff.w_addr[p], ww[p], st_ff.cfg.split, p[0]);
          for (int i = 0; i < emb_pkg::DW; i++) begin
            if (i < (32'd1 << ww[p])) begin
              nxt_st.mem[12'(base + 12'(i))] = st_ff.w_data[p][i];
            end
          end
        end
        // True dual and single ports do one operation per cycle
        r_do = st_ff.r_req[p] && !(st_ff.w_req[p] &&
               st_ff.cfg.mode != emb_pkg::EMB_QUAD &&
               st_ff.cfg.mode != emb_pkg::EMB_DP);
        base = bit_base(st_ff.r_addr[p], rw[p], st_ff.cfg.split, p[0]);
        rd = '0;
        for (int i = 0; i < emb_pkg::DW; i++) begin
          if (i < (32'd1 << rw[p])) begin
            rd[i] = st_ff.mem[12'(base + 12'(i))];
          end
        end
        // In input/output mode the read inputs follow the input enable
        rd_in_en = st_ff.cfg.clk_io ? ram_i[p].wr_clken :
                   ram_i[p].rd_clken;
        if (ram_i[p].clr || glb_clr_i) begin
          nxt_st.w_req[p] = 1'b0;
          nxt_st.w_addr[p] = '0;
          nxt_st.w_data[p] = '0;
          nxt_st.r_req[p] = 1'b0;
          nxt_st.r_addr[p] = '0;
          nxt_st.dout[p] = '0;
        end else begin
          if (ram_i[p].wr_clken) begin
            nxt_st.w_req[p] = ram_i[p].wreq && act[p] && !err;
            nxt_st.w_addr[p] = ram_i[p].waddr;
            nxt_st.w_data[p] = ram_i[p].wdata;
          end
          if (rd_in_en) begin
            nxt_st.r_req[p] = ram_i[p].read_strobe && act[p] && !err;
            nxt_st.r_addr[p] = (st_ff.cfg.mode == emb_pkg::EMB_SP) ?
                               ram_i[p].waddr : ram_i[p].raddr;
          end
          if (ram_i[p].rd_clken && r_do) begin
            nxt_st.dout[p] = rd;
          end
        end
      end

      // Searchable memory write: two cycles, three with don't-cares
      case (st_ff.cam_st)
        emb_pkg::EMB_IDLE: begin
          if (cam_i.we && st_ff.cfg.cam_en && !(cam_i.addr[4] &&
              st_ff.cfg.cam_mode == emb_pkg::EMB_FAST)) begin
            nxt_st.cw_addr = cam_i.addr;
            nxt_st.cw_data = cam_i.wdata;
            nxt_st.cw_care = cam_i.care;
            nxt_st.cam_st = emb_pkg::EMB_WR1;
          end
        end
        emb_pkg::EMB_WR1: begin
          nxt_st.cam_st = emb_pkg::EMB_WR2;
        end
        emb_pkg::EMB_WR2: begin
          if (&st_ff.cw_care) begin
            nxt_st.cam_data[st_ff.cw_addr] = st_ff.cw_data;
            nxt_st.cam_care[st_ff.cw_addr] = st_ff.cw_care;
            nxt_st.cam_vld[st_ff.cw_addr] = 1'b1;
            nxt_st.cam_st = emb_pkg::EMB_IDLE;
          end else begin
            nxt_st.cam_st = emb_pkg::EMB_WR3;
          end
        end
        emb_pkg::EMB_WR3: begin
          nxt_st.cam_data[st_ff.cw_addr] = st_ff.cw_data;
          nxt_st.cam_care[st_ff.cw_addr] = st_ff.cw_care;
          nxt_st.cam_vld[st_ff.cw_addr] = 1'b1;
          nxt_st.cam_st = emb_pkg::EMB_IDLE;
        end
        default: begin
          nxt_st.cam_st = emb_pkg::EMB_IDLE;
        end
      endcase

      // Search results
      if (st_ff.cam_ph) begin
        nxt_st.cam_ph = 1'b0;
        nxt_st.cout.valid = 1'b1;
        nxt_st.cout.lines = st_ff.hit_hold[31:16];
      end else if (cam_i.search && st_ff.cfg.cam_en) begin
        nxt_st.cout.valid = 1'b1;
        nxt_st.cout.match = |hits;
        nxt_st.cout.addr = lowest(hits);
        case (st_ff.cfg.cam_mode)
          emb_pkg::EMB_MULTI: begin
            nxt_st.cout.lines = hits[15:0];
            nxt_st.hit_hold = hits;
            nxt_st.cam_ph = 1'b1;
          end
          emb_pkg::EMB_FAST: begin
            nxt_st.cout.lines = hits[15:0];
          end
          default: begin
            for (int i = 0; i < emb_pkg::LINES; i++) begin
              nxt_st.cout.lines[i] =
                hits[2*i + int'(cam_i.key[emb_pkg::CAM_SEL_BIT])];
            end
          end
        endcase
      end
      if (glb_clr_i) begin
        nxt_st.cout = '0;
        nxt_st.cam_ph = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.cfg <= emb_pkg::CFG_RST;
      st_ff.cam_data <= CAM_INIT_DATA;
      st_ff.cam_care <= CAM_INIT_CARE;
      st_ff.cam_vld <= CAM_INIT_VLD;
      st_ff.cam_st <= emb_pkg::EMB_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.wb_dat;
  assign wb_ack_o = st_ff.ack;
  assign rdata_o = st_ff.dout;
  assign cam_o = st_ff.cout;
  assign cam_busy_o = st_ff.cam_st != emb_pkg::EMB_IDLE;
  assign cfg_err_o = err;
endmodule

// file: bench/emb_chk.sv
// Assertion checker for the embedded memory block ports
`timescale 1ns/10ps
module emb_chk (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic glb_clr_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input logic wb_ack_o,
  // Memory ports
  input emb_pkg::emb_ram_in_s [1:0] ram_i,
  input logic [1:0][emb_pkg::DW-1:0] rdata_o,
  input emb_pkg::emb_cam_in_s cam_i,
  input emb_pkg::emb_cam_out_s cam_o,
  input logic cam_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack;
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ack");
  property p_ack1;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack1: assert property (p_ack1)
    else $error("long ack");
  property p_wr2;
    $rose(cam_busy_o) && (&cam_i.care) |=> cam_busy_o ##1 !cam_busy_o;
  endproperty
  a_wr2: assert property (p_wr2)
    else $error("write not two cycles");
  property p_wr3;
    $rose(cam_busy_o) && !(&cam_i.care) |=> cam_busy_o[*2] ##1 !cam_busy_o;
  endproperty
  a_wr3: assert property (p_wr3)
    else $error("write not three cycles");
  property p_wrmax;
    cam_busy_o[*3] |=> !cam_busy_o;
  endproperty
  a_wrmax: assert property (p_wrmax)
    else $error("write too long");
  property p_glb;
    glb_clr_i && ce_i |=> rdata_o == '0;
  endproperty
  a_glb: assert property (p_glb)
    else $error("global clear missed");
  property p_loc;
    ram_i[1].clr && ce_i |=> rdata_o[1] == '0;
  endproperty
  a_loc: assert property (p_loc)
    else $error("local clear missed");
  property p_nom;
    cam_o.valid && !cam_o.match |-> cam_o.lines == '0;
  endproperty
  a_nom: assert property (p_nom)
    else $error("lines without match");
  c_hit: cover property (cam_o.valid && cam_o.match);
  c_wr3: cover property (cam_busy_o[*3]);
  c_two: cover property (cam_o.valid[*2]);
endmodule
bind emb_block emb_chk i_chk (
  .clk_i, .rst_i, .ce_i, .glb_clr_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .ram_i, .rdata_o, .cam_i, .cam_o, .cam_busy_o
);

// file: bench/emb_fab_model.sv
// Fabric-side model driving the memory block user ports
`timescale 1ns/10ps
module emb_fab_model (
  // Clock and block status
  input wire logic clk_i,
  input wire logic busy_i,
  input emb_pkg::emb_cam_out_s res_i,
  // Driven user ports
  output emb_pkg::emb_ram_in_s [1:0] ram_o,
  output emb_pkg::emb_cam_in_s srch_o
);
  initial begin
    ram_o = '0;
    srch_o = '0;
    ram_o[0].wr_clken = 1'b1;
    ram_o[0].rd_clken = 1'b1;
    ram_o[1].wr_clken = 1'b1;
    ram_o[1].rd_clken = 1'b1;
  end
  task automatic set(input int p, input logic w, input logic r,
                     input logic [11:0] a, input logic [31:0] d);
    ram_o[p].wreq <= w;
    ram_o[p].read_strobe <= r;
    ram_o[p].waddr <= a;
    ram_o[p].raddr <= a;
    ram_o[p].wdata <= d;
  endtask
  task automatic clr(input int p, input logic v);
    ram_o[p].clr <= v;
  endtask
  // Released data lines toggle so a stale value never looks valid
  task automatic idle();
    for (int p = 0; p < 2; p++) begin
      ram_o[p].wreq <= 1'b0;
      ram_o[p].read_strobe <= 1'b0;
      ram_o[p].wdata <= ~ram_o[p].wdata;
    end
    srch_o.we <= 1'b0;
    srch_o.search <= 1'b0;
    srch_o.wdata <= ~srch_o.wdata;
  endtask
  task automatic cam_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [31:0] c, output int n);
    n = 0;
    @(posedge clk_i);
    srch_o.we <= 1'b1;
    srch_o.addr <= a;
    srch_o.wdata <= d;
    srch_o.care <= c;
    @(posedge clk_i);
    idle();
    repeat (6) begin
      @(negedge clk_i);
      n += (busy_i === 1'b1) ? 1 : 0;
    end
  endtask
  task automatic find(input logic [31:0] k,
                      output emb_pkg::emb_cam_out_s r,
                      output emb_pkg::emb_cam_out_s r2);
    int n;
    n = 0;
    @(posedge clk_i);
    srch_o.search <= 1'b1;
    srch_o.key <= k;
    @(posedge clk_i);
    idle();
    do @(negedge clk_i); while (res_i.valid !== 1'b1 && ++n < 4);
    r = res_i;
    @(negedge clk_i);
    r2 = res_i;
  endtask
endmodule

// file: bench/emb_block_tb_top.sv
// Self-checking bench for the embedded memory block
`timescale 1ns/10ps
module emb_block_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, glb_clr_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, cam_busy_o, cfg_err_o;
  emb_pkg::emb_ram_in_s [1:0] ram_i;
  logic [1:0][emb_pkg::DW-1:0] rdata_o;
  emb_pkg::emb_cam_in_s cam_i;
  emb_pkg::emb_cam_out_s cam_o;
  int fail_count = 0, checked = 0;
  emb_block i_dut (
    .clk_i, .rst_i, .ce_i, .glb_clr_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ram_i,
    .rdata_o, .cam_i, .cam_o, .cam_busy_o, .cfg_err_o
  );
  emb_fab_model i_fab (
    .clk_i, .busy_i(cam_busy_o), .res_i(cam_o), .ram_o(ram_i),
    .srch_o(cam_i)
  );
  always #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic go();
    @(posedge clk_i);
    i_fab.idle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic t_ram();
    @(posedge clk_i);
    i_fab.set(0, 1'b1, 1'b0, 12'h003, 32'h0000_a5c3);
    i_fab.set(1, 1'b1, 1'b0, 12'h007, 32'h0000_3c5a);
    go();
    @(posedge clk_i);
    i_fab.set(0, 1'b1, 1'b0, 12'h003, 32'h0000_1111);
    i_fab.set(1, 1'b0, 1'b1, 12'h003, 32'h0);
    go();
    chk({16'h0, rdata_o[1][15:0]}, 32'h0000_a5c3);
    @(posedge clk_i);
    i_fab.set(0, 1'b0, 1'b1, 12'h007, 32'h0);
    i_fab.set(1, 1'b0, 1'b1, 12'h003, 32'h0);
    go();
    chk({16'h0, rdata_o[0][15:0]}, 32'h0000_3c5a);
    chk({16'h0, rdata_o[1][15:0]}, 32'h0000_1111);
    @(posedge clk_i);
    i_fab.clr(1, 1'b1);
    @(posedge clk_i);
    i_fab.clr(1, 1'b0);
    glb_clr_i <= 1'b1;
    @(negedge clk_i);
    chk({16'h0, rdata_o[0][15:0]}, 32'h0000_3c5a);
    chk(rdata_o[1], 32'h0);
    @(posedge clk_i);
    glb_clr_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o[0], 32'h0);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0004_4440);
    wb(1'b1, 8'h00, 32'h0004_4550, q);
    chk(32'(cfg_err_o), 32'h1);
    wb(1'b1, 8'h00, 32'h0004_4553, q);
    chk(32'(cfg_err_o), 32'h0);
    wb(1'b1, 8'h00, 32'h0004_4502, q);
    chk(32'(cfg_err_o), 32'h1);
    wb(1'b1, 8'h40, 32'hffff_ffff, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'h0004_4400, q);
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0004_4400);
  endtask
  task automatic t_mixed();
    @(posedge clk_i);
    i_fab.set(0, 1'b1, 1'b0, 12'h004, 32'h1);
    go();
    @(posedge clk_i);
    i_fab.set(0, 1'b0, 1'b1, 12'h000, 32'h0);
    go();
    chk({16'h0, rdata_o[0][15:0]}, 32'h0000_0010);
  endtask
  task automatic t_split();
    logic [31:0] q;
    wb(1'b1, 8'h00, 32'h0004_4446, q);
    @(posedge clk_i);
    i_fab.set(0, 1'b1, 1'b0, 12'h003, 32'h0000_7e81);
    i_fab.set(1, 1'b1, 1'b0, 12'h003, 32'h0000_c3c3);
    go();
    @(posedge clk_i);
    i_fab.set(0, 1'b0, 1'b1, 12'h003, 32'h0);
    i_fab.set(1, 1'b0, 1'b1, 12'h003, 32'h0);
    go();
    chk({16'h0, rdata_o[0][15:0]}, 32'h0000_7e81);
    chk({16'h0, rdata_o[1][15:0]}, 32'h0000_c3c3);
  endtask
  task automatic t_cam();
    emb_pkg::emb_cam_out_s r, r2;
    logic [31:0] q;
    int n;
    wb(1'b1, 8'h00, 32'h0094_4440, q);
    i_fab.cam_wr(5'd12, 32'h0abc_de12, '1, n);
    chk(n, 2);
    i_fab.cam_wr(5'd5, 32'h1234_5600, 32'hffff_ff00, n);
    chk(n, 3);
    i_fab.find(32'h0abc_de12, r, r2);
    chk(32'({r.valid, r.match, r.addr}), 32'h6c);
    i_fab.find(32'h1234_56ab, r, r2);
    chk(32'({r.match, r.addr}), 32'h25);
    i_fab.find(32'h1234_57ab, r, r2);
    chk(32'({r.valid, r.match}), 32'h2);
    wb(1'b1, 8'h00, 32'h0014_4440, q);
    i_fab.find(32'h0abc_de12, r, r2);
    chk(32'(r.lines), 32'h0040);
    i_fab.find(32'h9234_56ab, r, r2);
    chk(32'(r.lines), 32'h0004);
    wb(1'b1, 8'h00, 32'h00b4_4440, q);
    i_fab.cam_wr(5'd20, 32'h0abc_de12, '1, n);
    i_fab.find(32'h0abc_de12, r, r2);
    chk(32'({r.addr, r.lines}), 32'h000c_1000);
    chk(32'({r2.valid, r2.lines}), 32'h0001_0010);
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h0000_0c04);
    wb(1'b1, 8'h00, 32'h00d4_4440, q);
    i_fab.cam_wr(5'd17, 32'h0abc_de12, '1, n);
    chk(n, 0);
    i_fab.find(32'h0abc_de12, r, r2);
    chk(32'({r.addr, r.lines}), 32'h000c_1000);
    chk(32'(r2.valid), 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_ram();
    t_regs();
    t_mixed();
    t_split();
    t_cam();
    wrap_up();
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule
